// [front_end_cfg_pkg.sv]
package front_end_cfg_pkg;

  localparam int WORD_W = 24;
  localparam logic [23:0] WORD_RESET = 24'h00_0000;

  // General control word
  localparam int PD_RXF_BIT = 22;
  localparam int PD_PLL_BIT = 21;
  localparam int PD_VCO_BIT = 20;
  localparam int PD_TX_BIT = 19;
  localparam int TXPWR_HI = 18;
  localparam int TXPWR_LO = 17;
  localparam int CPI_HI = 16;
  localparam int CPI_LO = 14;
  localparam int LOPWR_HI = 13;
  localparam int LOPWR_LO = 12;
  localparam int LO_MUTE_BIT = 11;
  localparam int TX_MUTE_BIT = 10;
  localparam int TRISTATE_BIT = 9;
  localparam int POLARITY_BIT = 8;
  localparam int OUTMUX_HI = 7;
  localparam int OUTMUX_LO = 5;
  localparam int CNT_RST_BIT = 4;

  // Transmit/reference and calibration words share the top field layout
  localparam int RXPHASE_HI = 23;
  localparam int RXPHASE_LO = 21;
  localparam int MODPHASE_HI = 20;
  localparam int MODPHASE_LO = 18;
  localparam int BANDCLK_HI = 17;
  localparam int BANDCLK_LO = 16;
  localparam int REFDIV_HI = 15;
  localparam int REFDIV_LO = 3;
  localparam int CAL_START_BIT = 15;
  localparam int CALDIV_HI = 14;
  localparam int CALDIV_LO = 9;
  localparam int BOOST_HI = 8;
  localparam int BOOST_LO = 3;

  // LO divider word
  localparam int PRESCALE_HI = 23;
  localparam int PRESCALE_LO = 22;
  localparam int PUMP_GAIN_BIT = 21;
  localparam int FB_MUX_BIT = 20;
  localparam int BCOUNT_HI = 19;
  localparam int BCOUNT_LO = 7;
  localparam int ACOUNT_HI = 6;
  localparam int ACOUNT_LO = 2;

  // Receive filter word
  localparam int TEST_HI = 23;
  localparam int TEST_LO = 8;
  localparam int BOOST_EN_BIT = 7;
  localparam int BW_HI = 6;
  localparam int BW_LO = 5;
  localparam int RXGAIN_HI = 4;
  localparam int RXGAIN_LO = 2;

  // Multiplexed output pin sources
  localparam logic [2:0] MUX_LOW = 3'h0;
  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_CAL_TICK = 3'h2;
  localparam logic [2:0] MUX_BOOST = 3'h3;
  localparam logic [2:0] MUX_CAL_BUSY = 3'h4;
  localparam logic [2:0] MUX_HIGH = 3'h7;

  typedef enum logic [2:0] {
    DEST_CONTROL = 3'b000,
    DEST_TXREF = 3'b001,
    DEST_RXCAL = 3'b010,
    DEST_LODIV = 3'b011,
    DEST_RXFILT = 3'b100
  } dest_t;

  function automatic dest_t decode_dest(input logic [2:0] sel);
    dest_t d;
    d = DEST_CONTROL;
    unique case (sel[1:0])
      2'b00: d = DEST_CONTROL;
      2'b01: d = sel[2] ? DEST_RXCAL : DEST_TXREF;
      2'b10: d = DEST_LODIV;
      2'b11: d = DEST_RXFILT;
    endcase
    return d;
  endfunction

endpackage

// [serial_word_shifter.sv]
`timescale 1ns/1ns
module serial_word_shifter #(
  parameter int WORD_W = 24
) (
  input wire logic clock, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic shift_clk, // Serial shift clock, sampled
  input wire logic data_in, // Serial data
  output logic shift_edge, // Pulse on shift clock rise
  output logic [WORD_W-1:0] word_ff // Shifted word
);
  logic shift_clk_ff;

  if (WORD_W < 3) begin : g_bad_width
    $error("serial_word_shifter: word too narrow for the select bits");
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_clk_ff <= 1'b0;
    end else begin
      shift_clk_ff <= shift_clk;
    end
  end

  assign shift_edge = shift_clk & ~shift_clk_ff;

  // MSB goes in first, so it ends up at the top after a full word
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      word_ff <= '0;
    end else if (shift_edge) begin
      word_ff <= {word_ff[WORD_W-2:0], data_in};
    end
  end
endmodule

// [tick_divider.sv]
`timescale 1ns/1ns
module tick_divider #(
  parameter int DIV_W = 6
) (
  input wire logic clock, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic restart, // Clear the count
  input wire logic tick_in, // Input tick, one cycle
  input wire logic [DIV_W-1:0] ratio, // Divide ratio, zero stops
  output logic tick_out_ff // One pulse per ratio input ticks
);
  logic [DIV_W-1:0] count_ff;

  if (DIV_W < 1) begin : g_bad_width
    $error("tick_divider: divider width must be at least one");
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
      tick_out_ff <= 1'b0;
    end else if (restart || ratio == '0) begin
      count_ff <= '0;
      tick_out_ff <= 1'b0;
    end else if (tick_in) begin
      if (count_ff >= ratio - 1'b1) begin
        count_ff <= '0;
        tick_out_ff <= 1'b1;
      end else begin
        count_ff <= count_ff + 1'b1;
        tick_out_ff <= 1'b0;
      end
    end else begin
      tick_out_ff <= 1'b0;
    end
  end
endmodule

// [serial_config_latch_bank.sv]
// What this block does
// - Shift MSB first, load on strobe rise
// - Low bits zero pick general control word
// - Select 0,0,1 loads transmit/reference word
// - Select 1,0,1 loads calibration word
// - Select 1,0 loads LO; 1,1 loads filter
// - Four power-down bits, one powers section down
// - Two-bit transmit output power field
// - Three-bit charge pump current field
// - Two-bit LO output power field
// - LO lock-mute keeps LO off until lock
// - Tx lock-mute keeps Tx off until lock
// - Tristate bit floats the charge pump
// - Polarity bit: one positive, zero negative
// - Three-bit select drives multiplexed output pin
// - Counter reset bit holds the reference and feedback counters
// - Rx LO phase field, 90-degree steps or off
// - Modulation phase field picks mixer LO drive
// - Thirteen-bit reference divide ratio field
// - Calibration bit set starts filter calibration
// - Six-bit divider makes calibration clock
`timescale 1ns/1ns
module serial_config_latch_bank #(
  parameter int CAL_DIV_W = 6,
  parameter int BOOST_W = 6
) (
  input wire logic clock, // System clock, 125 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic serial_shift_clock, // Serial shift clock
  input wire logic serial_data_in, // Serial data, MSB first
  input wire logic serial_load_strobe, // Load strobe, rising edge loads
  input wire logic pll_locked, // Digital lock detect from the PLL
  input wire logic ref_in_tick, // One pulse per reference cycle
  output logic rx_filter_powerdown, // Rx filter power-down
  output logic pll_powerdown, // PLL power-down
  output logic vco_powerdown, // VCO power-down
  output logic tx_powerdown, // Tx power-down
  output logic [1:0] tx_power_sel, // Tx output power level
  output logic [2:0] pump_current, // Charge pump current setting two
  output logic [1:0] lo_power_sel, // LO output drive level
  output logic lo_output_on_ff, // LO outputs switched on
  output logic tx_output_on_ff, // Tx outputs switched on
  output logic pump_tristate, // Charge pump high impedance
  output logic detector_polarity, // One positive, zero negative
  output logic divider_hold_reset, // Reference and feedback counters held
  output logic multiplexed_output_pin, // Selected internal signal
  output logic [2:0] rx_lo_phase, // Demodulator LO phase
  output logic [2:0] mod_phase, // Mixer LO phase mode
  output logic [1:0] band_clk_div, // Band select clock divider code
  output logic [12:0] ref_div_ratio, // Reference divide ratio
  output logic [2:0] cal_rx_lo_phase, // Phase field of calibration word
  output logic [2:0] cal_mod_phase, // Modulation field of calibration word
  output logic [1:0] cal_band_clk_div, // Band clock field of calibration word
  output logic [CAL_DIV_W-1:0] cal_divider, // Calibration divider ratio
  output logic [BOOST_W-1:0] boost_timeout, // Boost timeout in calibration ticks
  output logic cal_start_ff, // Pulse: start filter calibration
  output logic cal_clock_tick, // Pulse: divided calibration clock
  output logic highpass_boost_on_ff, // High-pass boost charging
  output logic [1:0] prescale_sel, // Prescaler setting
  output logic pump_gain_max, // Maximum pump current chosen
  output logic fb_mux_sel, // Feedback mux select
  output logic [12:0] b_count, // B counter
  output logic [4:0] a_count, // A counter
  output logic band_select_start_ff, // Pulse: LO word updated
  output logic [15:0] test_mode_bits, // Test-mode bits
  output logic highpass_boost_enable, // Manual boost enable
  output logic [1:0] filter_bandwidth, // Rx filter bandwidth
  output logic [2:0] gain_select // Rx filter gain step
);

  localparam int W = front_end_cfg_pkg::WORD_W;

  // Slices rely on these widths
  if (CAL_DIV_W != front_end_cfg_pkg::CALDIV_HI - front_end_cfg_pkg::CALDIV_LO + 1) begin : g_bad_cal
    $error("serial_config_latch_bank: calibration divider width does not fit its field");
  end
  if (BOOST_W != front_end_cfg_pkg::BOOST_HI - front_end_cfg_pkg::BOOST_LO + 1) begin : g_bad_boost
    $error("serial_config_latch_bank: boost timeout width does not fit its field");
  end

  // Serial front end
  logic [W-1:0] shift_word;
  logic shift_edge;
  logic load_strobe_ff;
  logic load_edge;
  front_end_cfg_pkg::dest_t dest;

  // Latched words
  logic [W-1:0] control_word_ff;
  logic [W-1:0] txref_word_ff;
  logic [W-1:0] rxcal_word_ff;
  logic [W-1:0] lodiv_word_ff;
  logic [W-1:0] rxfilt_word_ff;

  // Calibration sequencing
  logic [BOOST_W-1:0] boost_left_ff;
  logic cal_busy_ff;

  // Output multiplexer
  logic [2:0] outmux_sel;
  logic nxt_mux;

  // Serial shift register
  serial_word_shifter #(
    .WORD_W(W)
  ) u_shifter (
    .clock(clock),
    .arst_n(arst_n),
    .shift_clk(serial_shift_clock),
    .data_in(serial_data_in),
    .shift_edge(shift_edge),
    .word_ff(shift_word)
  );

  // Load edge wins the word as it stood before any shift in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      load_strobe_ff <= 1'b0;
    end else begin
      load_strobe_ff <= serial_load_strobe;
    end
  end

  // Strobe rise
  assign load_edge = serial_load_strobe & ~load_strobe_ff;
  assign dest = front_end_cfg_pkg::decode_dest(shift_word[2:0]);

  // Load enable per latch
  function automatic logic loads(input front_end_cfg_pkg::dest_t d);
    return load_edge && dest == d;
  endfunction

  // The whole word is kept, select bits included, to keep slicing plain
  // Control word, x,0,0
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      control_word_ff <= front_end_cfg_pkg::WORD_RESET;
    end else if (loads(front_end_cfg_pkg::DEST_CONTROL)) begin
      control_word_ff <= shift_word;
    end
  end

  // Transmit word, 0,0,1
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txref_word_ff <= front_end_cfg_pkg::WORD_RESET;
    end else if (loads(front_end_cfg_pkg::DEST_TXREF)) begin
      txref_word_ff <= shift_word;
    end
  end

  // Calibration word, 1,0,1
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxcal_word_ff <= front_end_cfg_pkg::WORD_RESET;
    end else if (loads(front_end_cfg_pkg::DEST_RXCAL)) begin
      rxcal_word_ff <= shift_word;
    end
  end

  // LO word, x,1,0
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lodiv_word_ff <= front_end_cfg_pkg::WORD_RESET;
    end else if (loads(front_end_cfg_pkg::DEST_LODIV)) begin
      lodiv_word_ff <= shift_word;
    end
  end

  // Filter word, x,1,1
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxfilt_word_ff <= front_end_cfg_pkg::WORD_RESET;
    end else if (loads(front_end_cfg_pkg::DEST_RXFILT)) begin
      rxfilt_word_ff <= shift_word;
    end
  end

  // General control fields; reserved bits 3 and 2 are stored and unused
  assign rx_filter_powerdown = control_word_ff[front_end_cfg_pkg::PD_RXF_BIT];
  assign pll_powerdown = control_word_ff[front_end_cfg_pkg::PD_PLL_BIT];
  assign vco_powerdown = control_word_ff[front_end_cfg_pkg::PD_VCO_BIT];
  assign tx_powerdown = control_word_ff[front_end_cfg_pkg::PD_TX_BIT];

  // Drive levels
  assign tx_power_sel = control_word_ff[front_end_cfg_pkg::TXPWR_HI:front_end_cfg_pkg::TXPWR_LO];
  assign pump_current = control_word_ff[front_end_cfg_pkg::CPI_HI:front_end_cfg_pkg::CPI_LO];
  assign lo_power_sel = control_word_ff[front_end_cfg_pkg::LOPWR_HI:front_end_cfg_pkg::LOPWR_LO];

  // Loop and mux setup
  assign pump_tristate = control_word_ff[front_end_cfg_pkg::TRISTATE_BIT];
  assign detector_polarity = control_word_ff[front_end_cfg_pkg::POLARITY_BIT];
  assign outmux_sel = control_word_ff[front_end_cfg_pkg::OUTMUX_HI:front_end_cfg_pkg::OUTMUX_LO];
  assign divider_hold_reset = control_word_ff[front_end_cfg_pkg::CNT_RST_BIT];

  // Lock mute; a powered-down section stays off regardless
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lo_output_on_ff <= 1'b0;
    end else begin
      lo_output_on_ff <= ~vco_powerdown &
        ~(control_word_ff[front_end_cfg_pkg::LO_MUTE_BIT] & ~pll_locked);
    end
  end

  // Same gating for Tx
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_output_on_ff <= 1'b0;
    end else begin
      tx_output_on_ff <= ~tx_powerdown &
        ~(control_word_ff[front_end_cfg_pkg::TX_MUTE_BIT] & ~pll_locked);
    end
  end

  // Transmit/reference fields; band clock code is passed as written
  assign rx_lo_phase = txref_word_ff[front_end_cfg_pkg::RXPHASE_HI:front_end_cfg_pkg::RXPHASE_LO];
  assign mod_phase = txref_word_ff[front_end_cfg_pkg::MODPHASE_HI:front_end_cfg_pkg::MODPHASE_LO];
  assign band_clk_div = txref_word_ff[front_end_cfg_pkg::BANDCLK_HI:front_end_cfg_pkg::BANDCLK_LO];

  // Reference divider
  assign ref_div_ratio = txref_word_ff[front_end_cfg_pkg::REFDIV_HI:front_end_cfg_pkg::REFDIV_LO];

  // Calibration fields
  assign cal_rx_lo_phase = rxcal_word_ff[front_end_cfg_pkg::RXPHASE_HI:front_end_cfg_pkg::RXPHASE_LO];
  assign cal_mod_phase = rxcal_word_ff[front_end_cfg_pkg::MODPHASE_HI:front_end_cfg_pkg::MODPHASE_LO];
  assign cal_band_clk_div = rxcal_word_ff[front_end_cfg_pkg::BANDCLK_HI:front_end_cfg_pkg::BANDCLK_LO];

  // Divider and boost count
  assign cal_divider = rxcal_word_ff[front_end_cfg_pkg::CALDIV_HI:front_end_cfg_pkg::CALDIV_LO];
  assign boost_timeout = rxcal_word_ff[front_end_cfg_pkg::BOOST_HI:front_end_cfg_pkg::BOOST_LO];

  // Only a load of the calibration word with the start bit set triggers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_start_ff <= 1'b0;
    end else begin
      cal_start_ff <= loads(front_end_cfg_pkg::DEST_RXCAL) &&
        shift_word[front_end_cfg_pkg::CAL_START_BIT];
    end
  end

  // Divided reference; a zero ratio gives no ticks at all
  tick_divider #(
    .DIV_W(CAL_DIV_W)
  ) u_cal_div (
    .clock(clock),
    .arst_n(arst_n),
    .restart(cal_start_ff),
    .tick_in(ref_in_tick),
    .ratio(cal_divider),
    .tick_out_ff(cal_clock_tick)
  );

  // Boost runs for the timeout count of calibration ticks after a start
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boost_left_ff <= '0;
    end else if (cal_start_ff) begin
      boost_left_ff <= boost_timeout;
    end else if (cal_clock_tick && boost_left_ff != '0) begin
      boost_left_ff <= boost_left_ff - 1'b1;
    end
  end

  // Busy until first tick
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_busy_ff <= 1'b0;
    end else if (cal_start_ff) begin
      cal_busy_ff <= 1'b1;
    end else if (cal_clock_tick) begin
      cal_busy_ff <= 1'b0;
    end
  end

  // Zero timeout hands boost control to the manual enable bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      highpass_boost_on_ff <= 1'b0;
    end else if (boost_timeout == '0) begin
      highpass_boost_on_ff <= highpass_boost_enable;
    end else begin
      highpass_boost_on_ff <= boost_left_ff != '0;
    end
  end

  // LO divider fields
  assign prescale_sel = lodiv_word_ff[front_end_cfg_pkg::PRESCALE_HI:front_end_cfg_pkg::PRESCALE_LO];
  assign pump_gain_max = lodiv_word_ff[front_end_cfg_pkg::PUMP_GAIN_BIT];
  assign fb_mux_sel = lodiv_word_ff[front_end_cfg_pkg::FB_MUX_BIT];

  // Feedback counters
  assign b_count = lodiv_word_ff[front_end_cfg_pkg::BCOUNT_HI:front_end_cfg_pkg::BCOUNT_LO];
  assign a_count = lodiv_word_ff[front_end_cfg_pkg::ACOUNT_HI:front_end_cfg_pkg::ACOUNT_LO];

  // Every LO word update reruns band selection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      band_select_start_ff <= 1'b0;
    end else begin
      band_select_start_ff <= loads(front_end_cfg_pkg::DEST_LODIV);
    end
  end

  // Receive filter fields
  assign test_mode_bits = rxfilt_word_ff[front_end_cfg_pkg::TEST_HI:front_end_cfg_pkg::TEST_LO];
  assign highpass_boost_enable = rxfilt_word_ff[front_end_cfg_pkg::BOOST_EN_BIT];

  // Filter response
  assign filter_bandwidth = rxfilt_word_ff[front_end_cfg_pkg::BW_HI:front_end_cfg_pkg::BW_LO];
  assign gain_select = rxfilt_word_ff[front_end_cfg_pkg::RXGAIN_HI:front_end_cfg_pkg::RXGAIN_LO];

  // Output multiplexer; unassigned codes read low
  always_comb begin
    nxt_mux = 1'b0;
    unique case (outmux_sel)
      front_end_cfg_pkg::MUX_LOW: nxt_mux = 1'b0;
      front_end_cfg_pkg::MUX_LOCK: nxt_mux = pll_locked;
      front_end_cfg_pkg::MUX_CAL_TICK: nxt_mux = cal_clock_tick;
      front_end_cfg_pkg::MUX_BOOST: nxt_mux = highpass_boost_on_ff;
      front_end_cfg_pkg::MUX_CAL_BUSY: nxt_mux = cal_busy_ff;
      front_end_cfg_pkg::MUX_HIGH: nxt_mux = 1'b1;
      default: nxt_mux = 1'b0;
    endcase
  end

  // Registered against glitches
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      multiplexed_output_pin <= 1'b0;
    end else begin
      multiplexed_output_pin <= nxt_mux;
    end
  end

endmodule

// [host_serial_writer.sv]
`timescale 1ns/1ns
module host_serial_writer (
  input wire logic clock, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic go, // Start one frame
  input wire logic stall, // Pause the frame
  input wire logic [23:0] word, // Word to send
  output logic sclk_ff, // Shift clock
  output logic data_ff, // Serial data
  output logic strobe_ff, // Load strobe
  output logic busy_ff // Frame running
);
  logic [23:0] frame_ff;
  logic [6:0] step_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclk_ff <= 1'b0;
      data_ff <= 1'b0;
      strobe_ff <= 1'b0;
      busy_ff <= 1'b0;
      frame_ff <= 24'h00_0000;
      step_ff <= 7'h00;
    end else if (!busy_ff) begin
      // Idle data never holds a stale bit
      data_ff <= ~data_ff;
      if (go) begin
        busy_ff <= 1'b1;
        frame_ff <= word;
        step_ff <= 7'h00;
      end
    end else if (!stall) begin
      step_ff <= step_ff + 7'h01;
      if (step_ff < 7'h60) begin
        sclk_ff <= (step_ff[1:0] == 2'h1) || (step_ff[1:0] == 2'h2);
        if (step_ff[1:0] == 2'h0) begin
          data_ff <= frame_ff[5'd23 - step_ff[6:2]];
        end
      end else begin
        sclk_ff <= 1'b0;
        data_ff <= ~data_ff;
        strobe_ff <= (step_ff < 7'h62);
        busy_ff <= (step_ff != 7'h63);
      end
    end
  end
endmodule

// [latch_bank_checker.sv]
`timescale 1ns/1ns
module latch_bank_checker #(
  parameter int CAL_DIV_W = 6
) (
  input wire logic clock, // Clock
  input wire logic arst_n, // Reset
  input wire logic serial_load_strobe, // Strobe
  input wire logic pll_locked, // Lock
  input wire logic vco_powerdown, // VCO down
  input wire logic tx_powerdown, // Tx down
  input wire logic [2:0] pump_current, // Pump field
  input wire logic lo_output_on_ff, // LO on
  input wire logic tx_output_on_ff, // Tx on
  input wire logic [12:0] ref_div_ratio, // Ref ratio
  input wire logic [CAL_DIV_W-1:0] cal_divider, // Cal divider
  input wire logic cal_start_ff, // Cal start
  input wire logic cal_clock_tick, // Cal tick
  input wire logic [12:0] b_count, // B count
  input wire logic band_select_start_ff // LO load pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  sequence s_loaded;
    $past(serial_load_strobe) || $past(serial_load_strobe, 2);
  endsequence
  property p_ctl_load;
    $changed(pump_current) |-> s_loaded;
  endproperty
  a_ctl_load: assert property (p_ctl_load) else $error("ctl moved");
  property p_txref_load;
    $changed(ref_div_ratio) |-> s_loaded;
  endproperty
  a_txref_load: assert property (p_txref_load) else $error("ratio moved");
  property p_cal_load;
    $changed(cal_divider) |-> s_loaded;
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("divider moved");
  property p_lo_start;
    $changed(b_count) |-> ##[0:1] band_select_start_ff;
  endproperty
  a_lo_start: assert property (p_lo_start) else $error("no band start");
  property p_band_pulse;
    band_select_start_ff |=> !band_select_start_ff;
  endproperty
  a_band_pulse: assert property (p_band_pulse) else $error("band pulse long");
  property p_cal_src;
    cal_start_ff |-> s_loaded;
  endproperty
  a_cal_src: assert property (p_cal_src) else $error("stray cal start");
  property p_cal_once;
    cal_start_ff |=> !cal_start_ff;
  endproperty
  a_cal_once: assert property (p_cal_once) else $error("cal pulse long");
  property p_lo_lock;
    $past(arst_n) && $past(pll_locked) && !$past(vco_powerdown) |-> lo_output_on_ff;
  endproperty
  a_lo_lock: assert property (p_lo_lock) else $error("LO off while locked");
  property p_tx_lock;
    $past(arst_n) && $past(pll_locked) && !$past(tx_powerdown) |-> tx_output_on_ff;
  endproperty
  a_tx_lock: assert property (p_tx_lock) else $error("Tx off while locked");
  property p_pd_off;
    $past(tx_powerdown) |-> !tx_output_on_ff;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Tx on while down");
  property p_tick_zero;
    cal_divider == '0 && $past(cal_divider) == '0 |-> !cal_clock_tick;
  endproperty
  a_tick_zero: assert property (p_tick_zero) else $error("tick with zero divider");
  c_cal: cover property (cal_start_ff);
  c_band: cover property (band_select_start_ff);
  c_muted: cover property (!lo_output_on_ff && !vco_powerdown && !pll_locked && $past(arst_n));
endmodule

bind serial_config_latch_bank latch_bank_checker #(.CAL_DIV_W(CAL_DIV_W)) latch_bank_checker_inst (
  .clock(clock), .arst_n(arst_n), .serial_load_strobe(serial_load_strobe), .pll_locked(pll_locked),
  .vco_powerdown(vco_powerdown), .tx_powerdown(tx_powerdown), .pump_current(pump_current),
  .lo_output_on_ff(lo_output_on_ff), .tx_output_on_ff(tx_output_on_ff), .ref_div_ratio(ref_div_ratio),
  .cal_divider(cal_divider), .cal_start_ff(cal_start_ff), .cal_clock_tick(cal_clock_tick),
  .b_count(b_count), .band_select_start_ff(band_select_start_ff));

// [serial_config_latch_bank_tb.sv]
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module serial_config_latch_bank_tb;
  logic clock, arst_n, pll_locked, ref_in_tick, go, stall, busy;
  logic serial_shift_clock, serial_data_in, serial_load_strobe;
  logic [23:0] word;
  logic rx_filter_powerdown, pll_powerdown, vco_powerdown, tx_powerdown, lo_output_on_ff, tx_output_on_ff;
  logic pump_tristate, detector_polarity, divider_hold_reset, multiplexed_output_pin, cal_start_ff;
  logic cal_clock_tick, highpass_boost_on_ff, pump_gain_max, fb_mux_sel, band_select_start_ff, highpass_boost_enable;
  logic [1:0] tx_power_sel, lo_power_sel, band_clk_div, cal_band_clk_div, prescale_sel, filter_bandwidth;
  logic [2:0] pump_current, rx_lo_phase, mod_phase, cal_rx_lo_phase, cal_mod_phase, gain_select;
  logic [12:0] ref_div_ratio, b_count;
  logic [5:0] cal_divider, boost_timeout;
  logic [4:0] a_count;
  logic [15:0] test_mode_bits;
  int err_total = 0, num_checks = 0, cycles = 0, n_cal = 0, n_band = 0, n_tick = 0;

  serial_config_latch_bank serial_config_latch_bank_inst (.*);
  host_serial_writer host_serial_writer_inst (.clock(clock), .arst_n(arst_n), .go(go), .stall(stall), .word(word),
    .sclk_ff(serial_shift_clock), .data_ff(serial_data_in), .strobe_ff(serial_load_strobe), .busy_ff(busy));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    ref_in_tick <= (cycles % 4 == 0);
    n_cal += (cal_start_ff === 1'b1);
    n_band += (band_select_start_ff === 1'b1);
    n_tick += (cal_clock_tick === 1'b1);
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end

  task automatic send(input logic [23:0] w, input bit slow = 1'b0);
    int n;
    @(posedge clock);
    go <= 1'b1;
    word <= w;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      stall <= slow && n > 20 && n < 30;
      n++;
    end while (busy && n < 300);
    `CHK("frame done", 1'b0, busy)
    repeat (3) @(posedge clock);
  endtask

  task automatic t_control();
    logic [23:0] w;
    for (int i = 0; i < 2; i++) begin
      // Reserved pair always written 0,1
      w = i ? {1'b0, 4'h5, 7'h2A, 4'h5, 3'h4, 1'b0, 4'h4} : {1'b0, 4'hA, 7'h55, 4'hA, 3'h3, 1'b1, 4'h4};
      send(w);
      `CHK("powerdowns", w[22:19], {rx_filter_powerdown, pll_powerdown, vco_powerdown, tx_powerdown})
      `CHK("tx power", w[18:17], tx_power_sel)
      `CHK("pump current", w[16:14], pump_current)
      `CHK("lo power", w[13:12], lo_power_sel)
      `CHK("tristate", w[9], pump_tristate)
      `CHK("polarity", w[8], detector_polarity)
      `CHK("counter hold", w[4], divider_hold_reset)
    end
  endtask

  task automatic t_select();
    logic [23:0] t, c, l, f;
    t = {3'h5, 3'h2, 2'h3, 13'h15A3, 3'h1};
    c = {3'h3, 3'h4, 2'h3, 1'b0, 6'h2D, 6'h15, 3'h5};
    l = {2'h2, 1'b1, 1'b0, 13'h0A5B, 5'h13, 2'h2};
    f = {16'hC3A5, 1'b1, 2'h2, 3'h3, 2'h3};
    send(t);
    `CHK("lo phase", t[23:21], rx_lo_phase)
    `CHK("mod phase", t[20:18], mod_phase)
    `CHK("band clk", t[17:16], band_clk_div)
    `CHK("ref ratio", t[15:3], ref_div_ratio)
    `CHK("ctl kept", 3'h2, pump_current)
    send(c);
    `CHK("cal top", c[23:16], {cal_rx_lo_phase, cal_mod_phase, cal_band_clk_div})
    `CHK("cal divider", c[14:9], cal_divider)
    `CHK("boost count", c[8:3], boost_timeout)
    `CHK("txref kept", t[15:3], ref_div_ratio)
    `CHK("no cal start", 0, n_cal)
    send(l);
    `CHK("lo fields", l[23:2], {prescale_sel, pump_gain_max, fb_mux_sel, b_count, a_count})
    `CHK("band start", 1, n_band)
    send(f);
    `CHK("filter fields", f[23:2], {test_mode_bits, highpass_boost_enable, filter_bandwidth, gain_select})
    `CHK("lo kept", l[19:7], b_count)
  endtask

  task automatic t_mute_mux();
    pll_locked <= 1'b0;
    send({1'b0, 4'h0, 7'h00, 4'hC, 3'h1, 1'b0, 4'h4});
    `CHK("lo muted", 1'b0, lo_output_on_ff)
    `CHK("tx muted", 1'b0, tx_output_on_ff)
    `CHK("mux lock low", 1'b0, multiplexed_output_pin)
    pll_locked <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("lo on", 1'b1, lo_output_on_ff)
    `CHK("tx on", 1'b1, tx_output_on_ff)
    `CHK("mux lock high", 1'b1, multiplexed_output_pin)
    pll_locked <= 1'b0;
    send({1'b0, 4'h0, 7'h00, 4'h0, 3'h7, 1'b0, 4'h4});
    `CHK("lo unmuted", 1'b1, lo_output_on_ff)
    `CHK("mux high", 1'b1, multiplexed_output_pin)
    send({1'b0, 4'h3, 7'h00, 4'h0, 3'h0, 1'b0, 4'h4});
    `CHK("mux low", 1'b0, multiplexed_output_pin)
    `CHK("lo off", 1'b0, lo_output_on_ff)
    `CHK("tx off", 1'b0, tx_output_on_ff)
  endtask

  task automatic t_cal();
    int k;
    send({3'h7, 3'h0, 2'h3, 1'b1, 6'h02, 6'h00, 3'h5}, 1'b1);
    `CHK("cal start", 1, n_cal)
    `CHK("boost manual", 1'b1, highpass_boost_on_ff)
    k = n_tick;
    repeat (40) @(posedge clock);
    // Ten reference ticks through a divide by two
    `CHK("cal ticks", 1'b1, (n_tick - k) inside {[4:6]})
    send({3'h7, 3'h0, 2'h3, 1'b0, 6'h00, 6'h00, 3'h5});
    `CHK("cal start kept", 1, n_cal)
    k = n_tick;
    repeat (40) @(posedge clock);
    `CHK("no ticks", k, n_tick)
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    pll_locked = 1'b0;
    go = 1'b0;
    stall = 1'b0;
    word = 24'h00_0000;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_control();
    t_select();
    t_mute_mux();
    t_cal();
    final_report();
  end
endmodule
